// >>> hdl/adcc_cfg.svh
// Purpose: offsets, field positions, write masks and timing of the converter control
// Assumes: 32-bit AHB-Lite register words, hclk at 50 MHz
// Notes: definitions only
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ADCC_OFS_CTRL 8'h00
`define ADCC_OFS_CHSEL 8'h04
`define ADCC_OFS_AWDCFG 8'h08
`define ADCC_OFS_AWDMASK 8'h0C
`define ADCC_OFS_THR 8'h10
`define ADCC_OFS_DATA 8'h14
`define ADCC_OFS_STATUS 8'h18
`define ADCC_OFS_IE 8'h1C
`define ADCC_OFS_CALREF 8'h20
`define ADCC_OFS_CALTEMP 8'h24

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define ADCC_CTRL_EN 0
`define ADCC_CTRL_SCAN 1
`define ADCC_CTRL_TRIGEN 2
`define ADCC_CTRL_TRIGSEL 5:4
`define ADCC_CTRL_DMAEN 6
`define ADCC_CTRL_OSEN 7
`define ADCC_CTRL_OSSHIFT 11:8
`define ADCC_CTRL_START 12
`define ADCC_CTRL_WMASK 32'h00000FF7
`define ADCC_CHSEL_WMASK 32'h0007FFFF

// ---------------------------------------------------------------
// status and interrupt bits (same layout in mask register)
// ---------------------------------------------------------------
`define ADCC_ST_EOC 0
`define ADCC_ST_EOS 1
`define ADCC_ST_AWD 2
`define ADCC_ST_OVR 3
`define ADCC_ST_BUSY 8
`define ADCC_ST_W1C 4'hF

// ---------------------------------------------------------------
// channels
// ---------------------------------------------------------------
`define ADCC_NCH 19
`define ADCC_CH_LCD 5'h10
`define ADCC_CH_BANDGAP 5'h11
`define ADCC_CH_TEMP 5'h12
`define ADCC_OS_MAXSHIFT 4'h8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ADCC_CLK_MHZ 50
`define ADCC_PWRUP_NS 100
`define ADCC_PWRUP_CYC ((`ADCC_PWRUP_NS * `ADCC_CLK_MHZ + 999) / 1000)

`endif

// >>> hdl/adcc_pkg.sv
// Purpose: types shared by the converter control files
// Assumes: nothing
// Notes: constants live in adcc_cfg.svh
package adcc_pkg;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PWRUP = 3'b001,
		ST_CONV = 3'b010,
		ST_WAIT = 3'b011,
		ST_NEXT = 3'b100
	} adcc_state_t;

	// control toward the analog macro
	typedef struct packed {
		logic pwr;
		logic start;
		logic [4:0] ch;
	} adcc_ana_t;

	// captured ahb address phase
	typedef struct packed {
		logic vld;
		logic wr;
		logic [7:0] ofs;
	} adcc_aphase_t;
endpackage

// >>> hdl/adcc_oversampler.sv
// Purpose: accumulate raw samples and scale to a 16-bit result
// Assumes: shift is 0..8, held while a channel is being sampled
// Notes: raw mode passes the 12-bit sample straight through
`timescale 1ns/1ns
`default_nettype none
`include "adcc_cfg.svh"
module adcc_oversampler (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clr,
	input wire logic raw,
	input wire logic [3:0] shift,
	input wire logic smp_vld,
	input wire logic [11:0] smp,
	output logic res_vld,
	output logic [15:0] res
);
	import adcc_pkg::*;

	logic [19:0] acc_ff; // running sum, 256 x 4095 fits
	logic [8:0] cnt_ff; // samples taken so far
	logic [8:0] need; // samples per result
	logic [19:0] sum;
	logic [23:0] scaled;

	// shift clipped so a bad setting cannot overflow the sum
	assign need = raw ? 9'h001 : (9'h001 << ((shift > `ADCC_OS_MAXSHIFT) ? `ADCC_OS_MAXSHIFT : shift));
	assign sum = acc_ff + {8'h00, smp};
	// sum of 2^n samples times 16 over 2^n gives 16 bits
	assign scaled = {sum, 4'h0} >> ((shift > `ADCC_OS_MAXSHIFT) ? `ADCC_OS_MAXSHIFT : shift);

	// ---------------------------------------------------------------
	// accumulator
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_ff <= 20'h00000;
			cnt_ff <= 9'h000;
		end else if (clr) begin
			acc_ff <= 20'h00000;
			cnt_ff <= 9'h000;
		end else if (smp_vld) begin
			if (cnt_ff + 9'h001 >= need) begin
				acc_ff <= 20'h00000;
				cnt_ff <= 9'h000;
			end else begin
				acc_ff <= sum;
				cnt_ff <= cnt_ff + 9'h001;
			end
		end
	end

	// ---------------------------------------------------------------
	// result
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_vld <= 1'b0;
			res <= 16'h0000;
		end else begin
			res_vld <= smp_vld && !clr && (cnt_ff + 9'h001 >= need);
			if (smp_vld && !clr && (cnt_ff + 9'h001 >= need)) begin
				res <= raw ? {4'h0, smp} : scaled[15:0];
			end
		end
	end

	property p_raw_width;
		@(posedge hclk) disable iff (!hresetn)
		(smp_vld && raw && !clr) |=> (res_vld && res[15:12] == 4'h0 && res[11:0] == $past(smp));
	endproperty
	a_raw_width: assert property (p_raw_width) else $error("raw result not 12-bit sample");

	property p_count_cap;
		@(posedge hclk) disable iff (!hresetn)
		cnt_ff < 9'h100;
	endproperty
	a_count_cap: assert property (p_count_cap) else $error("more than 256 samples summed");
endmodule
`default_nettype wire

// >>> hdl/adcc_watchdog.sv
// Purpose: out-of-range check of delivered results
// Assumes: thresholds compare against the delivered 16-bit result
// Notes: one, some or all channels by mask
`timescale 1ns/1ns
`default_nettype none
`include "adcc_cfg.svh"
module adcc_watchdog (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic en,
	input wire logic [18:0] mask,
	input wire logic [15:0] lo,
	input wire logic [15:0] hi,
	input wire logic vld,
	input wire logic [4:0] ch,
	input wire logic [15:0] val,
	output logic hit
);
	import adcc_pkg::*;

	logic watched;

	// channels above the map are never watched
	assign watched = (ch < 5'(`ADCC_NCH)) && mask[ch];

	// ---------------------------------------------------------------
	// compare, one-cycle pulse
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hit <= 1'b0;
		end else begin
			hit <= vld && en && watched && ((val < lo) || (val > hi));
		end
	end

	property p_hit_cause;
		@(posedge hclk) disable iff (!hresetn)
		hit |-> $past(vld && en && mask[ch] && (val < lo || val > hi));
	endproperty
	a_hit_cause: assert property (p_hit_cause) else $error("watchdog hit without cause");
endmodule
`default_nettype wire

// >>> hdl/adcc_top.sv
// Purpose: control of the converter: sequencing, power gating, registers, dma, irq
// Assumes: analog macro raises conv_done_async after start, data stable with it
// Notes: zero-wait ahb-lite slave, read data chosen in the address phase
`timescale 1ns/1ns
`default_nettype none
`include "adcc_cfg.svh"
module adcc_top #(
	parameter logic [15:0] BANDGAP_CAL = 16'h0600, // arbitrary default
	parameter logic [15:0] TEMP_CAL_LO = 16'h0280, // arbitrary default
	parameter logic [15:0] TEMP_CAL_HI = 16'h0380 // arbitrary default
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [3:0] timer_trig,
	input wire logic conv_done_async,
	input wire logic [11:0] conv_data,
	output var adcc_pkg::adcc_ana_t ana_ctl,
	output logic dma_req,
	input wire logic dma_ack,
	output logic irq
);
	import adcc_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	adcc_aphase_t ap_ff; // pending data phase
	logic [31:0] ctrl_ff; // mode and option bits
	logic [18:0] chsel_ff; // channel group
	logic [31:0] awdcfg_ff; // bit 0 watchdog enable
	logic [18:0] awdmask_ff; // watched channels
	logic [31:0] thr_ff; // high in top half, low in bottom
	logic [31:0] data_ff; // channel and result
	logic [3:0] status_ff; // sticky events
	logic [3:0] ie_ff; // interrupt mask
	logic sw_start_ff; // start written last cycle
	logic [3:0] trig_d_ff; // last timer levels for edges
	adcc_state_t state_ff;
	adcc_state_t nxt_state;
	logic [4:0] ch_ff; // channel in conversion
	logic [3:0] pwr_cnt_ff; // power settle count
	logic done_s1_ff; // synchroniser stage one
	logic done_s2_ff; // synchroniser stage two
	logic done_d_ff; // for rising edge
	logic [11:0] smp_ff; // captured raw sample
	logic smp_vld_ff;
	logic os_clr_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	adcc_ana_t ana_ff;
	logic dma_req_ff;
	logic irq_ff;
	logic os_res_vld;
	logic [15:0] os_res;
	logic awd_hit;
	logic wr_go;
	logic acc_go;
	logic done_rise;
	logic trig_go;
	logic go;
	logic [5:0] first_ch;
	logic [5:0] next_ch;
	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	logic [31:0] rd_mux;

	// lowest selected channel above 'from'; bit 5 says found
	function automatic logic [5:0] find_ch(input logic [18:0] m, input int from);
		logic [5:0] r;
		r = 6'h00;
		for (int i = `ADCC_NCH - 1; i >= 0; i--) begin
			if (m[i] && i > from) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	assign first_ch = find_ch(chsel_ff, -1);
	assign next_ch = find_ch(chsel_ff, int'(ch_ff));

	// ---------------------------------------------------------------
	// ahb-lite slave
	// ---------------------------------------------------------------
	assign acc_go = hsel && htrans[1] && hready;
	assign wr_go = ap_ff.vld && ap_ff.wr;

	// address phase capture; only whole words are expected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_ff <= '0;
		end else begin
			ap_ff.vld <= acc_go;
			ap_ff.wr <= acc_go && hwrite;
			ap_ff.ofs <= acc_go ? haddr[7:0] : 8'h00;
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h00000000;
		if (haddr[7:0] == `ADCC_OFS_CTRL) begin
			rd_mux = ctrl_ff;
		end else if (haddr[7:0] == `ADCC_OFS_CHSEL) begin
			rd_mux = {13'h0000, chsel_ff};
		end else if (haddr[7:0] == `ADCC_OFS_AWDCFG) begin
			rd_mux = awdcfg_ff;
		end else if (haddr[7:0] == `ADCC_OFS_AWDMASK) begin
			rd_mux = {13'h0000, awdmask_ff};
		end else if (haddr[7:0] == `ADCC_OFS_THR) begin
			rd_mux = thr_ff;
		end else if (haddr[7:0] == `ADCC_OFS_DATA) begin
			rd_mux = data_ff;
		end else if (haddr[7:0] == `ADCC_OFS_STATUS) begin
			rd_mux = {23'h000000, (state_ff != ST_IDLE), 4'h0, status_ff};
		end else if (haddr[7:0] == `ADCC_OFS_IE) begin
			rd_mux = {28'h0000000, ie_ff};
		end else if (haddr[7:0] == `ADCC_OFS_CALREF) begin
			rd_mux = {16'h0000, BANDGAP_CAL};
		end else if (haddr[7:0] == `ADCC_OFS_CALTEMP) begin
			rd_mux = {TEMP_CAL_HI, TEMP_CAL_LO};
		end
	end

	// read data and response flops; writes to calibration words are ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h00000000;
			hreadyout_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
			if (acc_go && !hwrite) begin
				hrdata_ff <= rd_mux;
			end
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= 32'h00000000;
			chsel_ff <= 19'h00000;
			awdcfg_ff <= 32'h00000000;
			awdmask_ff <= 19'h00000;
			thr_ff <= 32'hFFFF0000;
			ie_ff <= 4'h0;
			sw_start_ff <= 1'b0;
		end else begin
			sw_start_ff <= wr_go && (ap_ff.ofs == `ADCC_OFS_CTRL) && hwdata[`ADCC_CTRL_START];
			if (wr_go && ap_ff.ofs == `ADCC_OFS_CTRL) begin
				ctrl_ff <= hwdata & `ADCC_CTRL_WMASK;
			end else if (wr_go && ap_ff.ofs == `ADCC_OFS_CHSEL) begin
				chsel_ff <= hwdata[18:0];
			end else if (wr_go && ap_ff.ofs == `ADCC_OFS_AWDCFG) begin
				awdcfg_ff <= {31'h00000000, hwdata[0]};
			end else if (wr_go && ap_ff.ofs == `ADCC_OFS_AWDMASK) begin
				awdmask_ff <= hwdata[18:0];
			end else if (wr_go && ap_ff.ofs == `ADCC_OFS_THR) begin
				thr_ff <= hwdata;
			end else if (wr_go && ap_ff.ofs == `ADCC_OFS_IE) begin
				ie_ff <= hwdata[3:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// start sources
	// ---------------------------------------------------------------
	// timers share hclk, so their levels need no synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_d_ff <= 4'h0;
		end else begin
			trig_d_ff <= timer_trig;
		end
	end

	assign trig_go = ctrl_ff[`ADCC_CTRL_TRIGEN] &&
		timer_trig[ctrl_ff[`ADCC_CTRL_TRIGSEL]] && !trig_d_ff[ctrl_ff[`ADCC_CTRL_TRIGSEL]];
	assign go = ctrl_ff[`ADCC_CTRL_EN] && (sw_start_ff || trig_go) && first_ch[5];

	// ---------------------------------------------------------------
	// conversion done from the analog clock
	// ---------------------------------------------------------------
	// macro runs on its own clock; only stage two is looked at
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_s1_ff <= 1'b0;
			done_s2_ff <= 1'b0;
			done_d_ff <= 1'b0;
		end else begin
			done_s1_ff <= conv_done_async;
			done_s2_ff <= done_s1_ff;
			done_d_ff <= done_s2_ff;
		end
	end

	assign done_rise = done_s2_ff && !done_d_ff;

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// a start while busy is dropped rather than queued
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (go) begin
					nxt_state = ST_PWRUP;
				end
			end
			ST_PWRUP: begin
				if (pwr_cnt_ff == 4'h0) begin
					nxt_state = ST_CONV;
				end
			end
			ST_CONV: begin
				nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (done_rise) begin
					nxt_state = ST_NEXT;
				end
			end
			ST_NEXT: begin
				// oversampler answers one cycle after the sample, so wait for it
				if (smp_vld_ff) begin
					nxt_state = ST_NEXT;
				end else if (!os_res_vld) begin
					nxt_state = ST_CONV;
				end else if (ctrl_ff[`ADCC_CTRL_SCAN] && next_ch[5]) begin
					nxt_state = ST_CONV;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// state, channel and power-up counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= ST_IDLE;
			ch_ff <= 5'h00;
			pwr_cnt_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == ST_IDLE && go) begin
				ch_ff <= first_ch[4:0];
				pwr_cnt_ff <= 4'(`ADCC_PWRUP_CYC - 1);
			end else if (state_ff == ST_PWRUP && pwr_cnt_ff != 4'h0) begin
				pwr_cnt_ff <= pwr_cnt_ff - 4'h1;
			end else if (state_ff == ST_NEXT && os_res_vld && next_ch[5]) begin
				ch_ff <= next_ch[4:0];
			end
		end
	end

	// analog control; channels 16..18 reach lcd node, bandgap, sensor
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ana_ff <= '0;
		end else begin
			ana_ff.pwr <= (nxt_state != ST_IDLE);
			ana_ff.start <= (state_ff == ST_CONV);
			ana_ff.ch <= (nxt_state == ST_IDLE) ? 5'h00 : ch_ff;
		end
	end

	// sample capture and accumulator clear at each start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			smp_ff <= 12'h000;
			smp_vld_ff <= 1'b0;
			os_clr_ff <= 1'b0;
		end else begin
			smp_vld_ff <= (state_ff == ST_WAIT) && done_rise;
			os_clr_ff <= (state_ff == ST_IDLE) && go;
			if (state_ff == ST_WAIT && done_rise) begin
				smp_ff <= conv_data;
			end
		end
	end

	adcc_oversampler u_os (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(os_clr_ff),
		.raw(!ctrl_ff[`ADCC_CTRL_OSEN]),
		.shift(ctrl_ff[`ADCC_CTRL_OSSHIFT]),
		.smp_vld(smp_vld_ff),
		.smp(smp_ff),
		.res_vld(os_res_vld),
		.res(os_res)
	);

	adcc_watchdog u_awd (
		.hclk(hclk),
		.hresetn(hresetn),
		.en(awdcfg_ff[0]),
		.mask(awdmask_ff),
		.lo(thr_ff[15:0]),
		.hi(thr_ff[31:16]),
		.vld(os_res_vld),
		.ch(ch_ff),
		.val(os_res),
		.hit(awd_hit)
	);

	// ---------------------------------------------------------------
	// result, dma, status and interrupt
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_ff <= 32'h00000000;
			dma_req_ff <= 1'b0;
		end else begin
			if (os_res_vld) begin
				data_ff <= {11'h000, ch_ff, os_res};
			end
			// new result keeps the request high even if acked now
			if (os_res_vld && ctrl_ff[`ADCC_CTRL_DMAEN]) begin
				dma_req_ff <= 1'b1;
			end else if (dma_ack) begin
				dma_req_ff <= 1'b0;
			end
		end
	end

	assign ev_set[`ADCC_ST_EOC] = os_res_vld;
	assign ev_set[`ADCC_ST_EOS] = (state_ff == ST_NEXT) && (nxt_state == ST_IDLE);
	assign ev_set[`ADCC_ST_AWD] = awd_hit;
	assign ev_set[`ADCC_ST_OVR] = os_res_vld && dma_req_ff && !dma_ack;
	assign ev_clr = (wr_go && ap_ff.ofs == `ADCC_OFS_STATUS) ? (hwdata[3:0] & `ADCC_ST_W1C) : 4'h0;

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_ff <= 4'h0;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= (status_ff & ~ev_clr) | ev_set;
			irq_ff <= |(((status_ff & ~ev_clr) | ev_set) & ie_ff);
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;
	assign ana_ctl = ana_ff;
	assign dma_req = dma_req_ff;
	assign irq = irq_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_idle_off;
		@(posedge hclk) disable iff (!hresetn)
		(state_ff == ST_IDLE && $past(state_ff) == ST_IDLE) |-> !ana_ff.pwr;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("analog powered while idle");

	property p_settle;
		@(posedge hclk) disable iff (!hresetn)
		$rose(state_ff == ST_PWRUP) |-> (state_ff == ST_PWRUP && ana_ff.pwr)[*5] ##2 ana_ff.start;
	endproperty
	a_settle: assert property (p_settle) else $error("start before power settled");

	property p_start_pulse;
		@(posedge hclk) disable iff (!hresetn)
		ana_ff.start |-> ana_ff.pwr ##1 !ana_ff.start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start not a powered pulse");

	property p_ch_range;
		@(posedge hclk) disable iff (!hresetn)
		ana_ff.start |-> (ana_ff.ch <= `ADCC_CH_TEMP) && chsel_ff[ana_ff.ch];
	endproperty
	a_ch_range: assert property (p_ch_range) else $error("unselected channel converted");

	property p_ascend;
		@(posedge hclk) disable iff (!hresetn)
		(state_ff == ST_NEXT && os_res_vld && nxt_state == ST_CONV) |=> (ch_ff > $past(ch_ff));
	endproperty
	a_ascend: assert property (p_ascend) else $error("scan order not ascending");

	property p_eoc;
		@(posedge hclk) disable iff (!hresetn)
		os_res_vld |=> status_ff[`ADCC_ST_EOC] && data_ff[15:0] == $past(os_res);
	endproperty
	a_eoc: assert property (p_eoc) else $error("result without complete flag");

	property p_awd_irq;
		@(posedge hclk) disable iff (!hresetn)
		(awd_hit && ie_ff[`ADCC_ST_AWD]) |=> irq;
	endproperty
	a_awd_irq: assert property (p_awd_irq) else $error("watchdog event gave no irq");

	property p_dma;
		@(posedge hclk) disable iff (!hresetn)
		(os_res_vld && ctrl_ff[`ADCC_CTRL_DMAEN]) |=> dma_req;
	endproperty
	a_dma: assert property (p_dma) else $error("no dma request for result");

	property p_trig;
		@(posedge hclk) disable iff (!hresetn)
		(state_ff == ST_IDLE && trig_go && ctrl_ff[`ADCC_CTRL_EN] && first_ch[5])
			|=> state_ff == ST_PWRUP ##1 ana_ff.pwr;
	endproperty
	a_trig: assert property (p_trig) else $error("timer edge did not start");
endmodule
`default_nettype wire

// >>> tb/adcc_ana_model.sv
// Purpose: analog converter macro as seen from the control block
// Assumes: start is a one-cycle pulse while power is on
// Notes: the sample depends on the channel only, so results are predictable
`timescale 1ns/1ns
`default_nettype none
module adcc_ana_model (
	input wire logic hclk,
	input wire adcc_pkg::adcc_ana_t ana_ctl,
	input wire logic [3:0] dly,
	output logic conv_done_async,
	output logic [11:0] conv_data
);
	import adcc_pkg::*;
	// ---------------------------------------------
	// conversion timing, done is not hclk aligned
	// ---------------------------------------------
	initial begin
		logic [4:0] ch;
		conv_done_async = 1'b0;
		conv_data = 12'hA5A;
		forever begin
			@(posedge hclk iff ana_ctl.start === 1'b1);
			ch = ana_ctl.ch; // channel latched at start
			repeat (dly) @(posedge hclk);
			#3 conv_data = 12'(ch * 200 + 7);
			conv_done_async = 1'b1;
			repeat (3) @(posedge hclk);
			#3 conv_done_async = 1'b0;
			conv_data = ~conv_data; // hold time over: no stale value
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_adc_conversion_control.sv
// Purpose: self-checking bench of the converter control
// Assumes: zero-wait slave, dma drains every result
// Notes: expected results come from a channel queue model
`timescale 1ns/1ns
`default_nettype none
`include "adcc_cfg.svh"
module tb_adc_conversion_control;
	import adcc_pkg::*;
	localparam logic [15:0] BGC = 16'h0ABC; // arbitrary
	localparam logic [15:0] TCL = 16'h0123; // arbitrary
	localparam logic [15:0] TCH = 16'h0456; // arbitrary
	logic hclk, hresetn, hsel, hwrite, dma_ack, hreadyout, hresp, done, dma_req, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] timer_trig, dly;
	logic [11:0] cdata;
	adcc_ana_t ana_ctl;
	int n_mismatch, checked;
	adcc_top #(.BANDGAP_CAL(BGC), .TEMP_CAL_LO(TCL), .TEMP_CAL_HI(TCH)) dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .timer_trig(timer_trig), .conv_done_async(done),
		.conv_data(cdata), .ana_ctl(ana_ctl), .dma_req(dma_req), .dma_ack(dma_ack), .irq(irq));
	adcc_ana_model ana (.hclk(hclk), .ana_ctl(ana_ctl), .dly(dly), .conv_done_async(done),
		.conv_data(cdata));
	// ---------------------------------------------
	// clock, checks, closing
	// ---------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_of_test;
		$display("mismatches=%0d checks=%0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic timeout;
		n_mismatch++;
		end_of_test();
	endtask
	// power must be on whenever the macro is started
	always @(posedge hclk) if (ana_ctl.start === 1'b1) chk(ana_ctl.pwr, 1'b1);
	// ---------------------------------------------
	// ahb-lite master, waits on hready each phase
	// ---------------------------------------------
	task automatic rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) timeout();
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy();
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	// one conversion run; results drained through dma reads
	task automatic run(input logic [31:0] c, input logic [18:0] s, input logic trg);
		int q[$];
		int k;
		logic [31:0] r;
		dly <= 4'd3 + 4'($urandom % 4); // quick and slow converter
		wr(`ADCC_OFS_CHSEL, {13'h0, s});
		wr(`ADCC_OFS_CTRL, c);
		for (k = 0; k < `ADCC_NCH; k++) begin
			if (s[k] && (c[1] || q.size() == 0)) q.push_back((k << 16) | (((k * 200 + 7) & 12'hFFF) << (c[7] ? 4 : 0)));
		end
		if (trg) timer_trig <= 4'h8;
		else wr(`ADCC_OFS_CTRL, c | 32'h1000);
		while (q.size() > 0) begin
			for (k = 0; k < 5000 && dma_req !== 1'b1; k++) @(posedge hclk);
			if (dma_req !== 1'b1) timeout();
			xfer(1'b0, `ADCC_OFS_DATA, 32'h0, r);
			chk(r, q.pop_front());
			dma_ack <= 1'b1;
			@(posedge hclk);
			dma_ack <= 1'b0;
			@(posedge hclk);
		end
		timer_trig <= 4'h0;
		for (k = 0; k < 100 && ana_ctl.pwr !== 1'b0; k++) @(posedge hclk);
		chk(ana_ctl.pwr, 1'b0);
		chk(dma_req, 1'b0);
	endtask
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		logic [31:0] r;
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, timer_trig, dma_ack} = '0;
		hsize = 3'b010;
		dly = 4'd3;
		n_mismatch = 0;
		checked = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		void'($urandom(32'h08A2A2C7));
		xfer(1'b0, `ADCC_OFS_THR, 32'h0, r);
		chk(r, 32'hFFFF0000);
		chk(hresp, 1'b0);
		wr(`ADCC_OFS_CALREF, 32'hFFFFFFFF);
		xfer(1'b0, `ADCC_OFS_CALREF, 32'h0, r);
		chk(r, {16'h0, BGC});
		xfer(1'b0, `ADCC_OFS_CALTEMP, 32'h0, r);
		chk(r, {TCH, TCL});
		xfer(1'b0, 8'h40, 32'h0, r);
		chk(r, 32'h0);
		run(32'h41, 19'h70000, 1'b0); // single: lowest channel only
		xfer(1'b0, `ADCC_OFS_STATUS, 32'h0, r);
		chk(r, 32'h00000003);
		run(32'h43, 19'h60000, 1'b0);
		run(32'h43, 19'($urandom | 1), 1'b0);
		run(32'h8C1, 19'h00004, 1'b0); // 256 samples
		run(32'h75, 19'h00100, 1'b1); // timer line 3 starts it
		wr(`ADCC_OFS_STATUS, 32'hF);
		wr(`ADCC_OFS_AWDMASK, 32'h20);
		wr(`ADCC_OFS_THR, 32'h00640000);
		wr(`ADCC_OFS_AWDCFG, 32'h1);
		wr(`ADCC_OFS_IE, 32'h4);
		run(32'h43, 19'h00021, 1'b0);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b1);
		xfer(1'b0, `ADCC_OFS_STATUS, 32'h0, r);
		chk(r[2], 1'b1);
		wr(`ADCC_OFS_STATUS, 32'h4);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
